// ---- design/bsis_input_module.v ----
// input module: stream sampler, observe-time clock, monitor pulse, aux serial receiver
`include "bsis_consts.vh"
module bsis_input_module #(
  parameter integer CLK_HZ      = `BSIS_SAMPLE_CLK_HZ,
  parameter integer MON_CYCLES  = (`BSIS_SAMPLE_CLK_HZ / 1000000) * `BSIS_MON_STRETCH_US,
  parameter integer BAUD_CYCLES = `BSIS_SAMPLE_CLK_HZ / `BSIS_BAUD
) (
  input  wire                          clk,
  input  wire                          rst,
  input  wire [`BSIS_NUM_STREAMS-1:0]  inputBitStream,
  input  wire                          secondTick,
  input  wire                          alternateSecondTick,
  input  wire                          auxSerialInput,
  input  wire [`BSIS_KSEL_W-1:0]       rateSel,
  input  wire [`BSIS_SUBSET_W-1:0]     subsetSel,
  input  wire                          useAltTick,
  input  wire                          armSet,
  input  wire [`BSIS_SEC_W-1:0]        setSeconds,
  output reg  [`BSIS_NUM_STREAMS-1:0]  sampleDataQ,
  output reg                           sampleValidQ,
  output reg                           onSecondSampleQ,
  output reg                           observeTimeMonitorQ,
  output reg  [`BSIS_SEC_W-1:0]        observeSecondsQ,
  output reg                           observeSetQ,
  output reg  [7:0]                    auxDataQ,
  output reg                           auxValidQ,
  output reg                           auxOverrunQ
);
  // ----------------------------------------
  // input synchronisers
  // ----------------------------------------
  // streams and tick share the source clock, but still cross two stages; skew is equal
  reg [`BSIS_NUM_STREAMS-1:0] bsMeta_q;
  reg [`BSIS_NUM_STREAMS-1:0] bsSync_q;
  reg [2:0]                   tickMeta_q;
  reg [2:0]                   tickSync_q;
  reg                         tickPrev_q;
  reg                         altPrev_q;

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      bsMeta_q   <= {`BSIS_NUM_STREAMS{1'b0}};
      bsSync_q   <= {`BSIS_NUM_STREAMS{1'b0}};
      // aux line idles high; a low reset value would fake a start bit
      tickMeta_q <= `BSIS_SYNC_IDLE;
      tickSync_q <= `BSIS_SYNC_IDLE;
      tickPrev_q <= 1'b0;
      altPrev_q  <= 1'b0;
    end else begin
      bsMeta_q   <= inputBitStream;
      bsSync_q   <= bsMeta_q;
      tickMeta_q <= {auxSerialInput, alternateSecondTick, secondTick};
      tickSync_q <= tickMeta_q;
      tickPrev_q <= tickSync_q[0];
      altPrev_q  <= tickSync_q[1];
    end
  end

  // ----------------------------------------
  // tick edge detection
  // ----------------------------------------
  // previous values reset low, matching the idle level of both tick pins
  wire tickRise = tickSync_q[0] & ~tickPrev_q;
  wire altRise  = tickSync_q[1] & ~altPrev_q;
  wire selRise  = useAltTick ? altRise : tickRise;

  // ----------------------------------------
  // sampling phase and phase mask
  // ----------------------------------------
  reg  [`BSIS_CNT_W-1:0] phase_q;
  wire [`BSIS_KSEL_W-1:0] kEff = (rateSel > `BSIS_KMAX) ? `BSIS_KMAX : rateSel;
  wire [`BSIS_CNT_W-1:0] phaseMask = ({{(`BSIS_CNT_W-1){1'b0}}, 1'b1} << kEff) - 1'b1;

  // ----------------------------------------
  // active subset
  // ----------------------------------------
  wire [`BSIS_SUBSET_W-1:0] sEff = (subsetSel > `BSIS_SUBSET_MAX) ? `BSIS_SUBSET_MAX : subsetSel;
  // number of active streams, a power of two up to sixteen
  wire [5:0] subsetCount = 6'h01 << sEff;
  wire [`BSIS_NUM_STREAMS-1:0] subsetMask =
    ({{(`BSIS_NUM_STREAMS-1){1'b0}}, 1'b1} << subsetCount) - 1'b1;
  wire sampleNow = tickRise | ((phase_q & phaseMask) == {`BSIS_CNT_W{1'b0}});

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      phase_q         <= {`BSIS_CNT_W{1'b0}};
      sampleDataQ     <= {`BSIS_NUM_STREAMS{1'b0}};
      sampleValidQ    <= 1'b0;
      onSecondSampleQ <= 1'b0;
    end else begin
      // tick restarts the phase so the on-second bit is sample zero
      phase_q         <= tickRise ? {{(`BSIS_CNT_W-1){1'b0}}, 1'b1} : phase_q + 1'b1;
      sampleValidQ    <= sampleNow;
      onSecondSampleQ <= tickRise;
      if (sampleNow) begin
        sampleDataQ <= bsSync_q & subsetMask;
      end
    end
  end

  // ----------------------------------------
  // observe-time clock and monitor
  // ----------------------------------------
  reg [`BSIS_CNT_W-1:0] secCnt_q;
  reg [`BSIS_CNT_W-1:0] monCnt_q;
  reg                   armed_q;

  // ----------------------------------------
  // arming for the next selected tick
  // ----------------------------------------
  // arm request wins over the consuming tick in the same cycle
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      armed_q <= 1'b0;
    end else if (armSet) begin
      armed_q <= 1'b1;
    end else if (armed_q && selRise) begin
      armed_q <= 1'b0;
    end
  end

  // ----------------------------------------
  // second counting and monitor stretch
  // ----------------------------------------
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      secCnt_q            <= {`BSIS_CNT_W{1'b0}};
      monCnt_q            <= {`BSIS_CNT_W{1'b0}};
      observeSetQ         <= 1'b0;
      observeSecondsQ     <= {`BSIS_SEC_W{1'b0}};
      observeTimeMonitorQ <= 1'b0;
    end else begin
      // re-setting from an async tick may jump one cycle
      if (armed_q && selRise) begin
        observeSetQ     <= 1'b1;
        observeSecondsQ <= setSeconds;
        // tick cycle itself is count zero, so a full second follows
        secCnt_q        <= {`BSIS_CNT_W{1'b0}};
        monCnt_q        <= MON_CYCLES[`BSIS_CNT_W-1:0];
      end else if (observeSetQ) begin
        // later ticks ignored; drift against the tick source clock is not tracked, seconds run on this clock alone
        if (secCnt_q == CLK_HZ[`BSIS_CNT_W-1:0] - 1'b1) begin
          secCnt_q        <= {`BSIS_CNT_W{1'b0}};
          observeSecondsQ <= observeSecondsQ + 1'b1;
          monCnt_q        <= MON_CYCLES[`BSIS_CNT_W-1:0];
        end else begin
          secCnt_q <= secCnt_q + 1'b1;
          if (monCnt_q != {`BSIS_CNT_W{1'b0}}) begin
            monCnt_q <= monCnt_q - 1'b1;
          end
        end
      end
      observeTimeMonitorQ <= observeSetQ && (monCnt_q != {`BSIS_CNT_W{1'b0}});
    end
  end

  // ----------------------------------------
  // auxiliary serial input
  // ----------------------------------------
  wire [7:0] rxData;
  wire       rxValid;
  reg  [`BSIS_BURST_W:0] burst_q;

  bsis_uart_rx #(
    .BIT_CYCLES (BAUD_CYCLES)
  ) uRx (
    .clk       (clk),
    .rst       (rst),
    .rxIn      (tickSync_q[2]),
    .dataQ     (rxData),
    .validQ    (rxValid),
    .frameErrQ ()
  );

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      auxDataQ    <= 8'h00;
      auxValidQ   <= 1'b0;
    end else begin
      // bytes are forwarded for a future time update
      auxValidQ <= rxValid;
      if (rxValid) begin
        auxDataQ <= rxData;
      end
    end
  end

  // ----------------------------------------
  // burst length between second ticks
  // ----------------------------------------
  // overflow only flagged; bytes keep flowing for the consumer to judge
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      burst_q     <= {(`BSIS_BURST_W+1){1'b0}};
      auxOverrunQ <= 1'b0;
    end else if (tickRise) begin
      burst_q     <= {{`BSIS_BURST_W{1'b0}}, rxValid};
      auxOverrunQ <= 1'b0;
    end else if (rxValid) begin
      burst_q <= burst_q + 1'b1;
      if (burst_q >= `BSIS_BURST_MAX) begin
        auxOverrunQ <= 1'b1;
      end
    end
  end
endmodule

// ---- include/bsis_consts.vh ----
// constants for the bit stream input sampler
`ifndef BSIS_CONSTS_VH
`define BSIS_CONSTS_VH
`define BSIS_NUM_STREAMS      32
`define BSIS_KSEL_W           3
`define BSIS_KMAX             3'h7
`define BSIS_SUBSET_W         3
`define BSIS_SUBSET_MAX       3'h4
`define BSIS_SAMPLE_CLK_HZ    32000000
`define BSIS_MON_STRETCH_US   10000
`define BSIS_BAUD             115000
`define BSIS_UART_BITS        8
`define BSIS_BURST_MAX        2048
`define BSIS_SEC_W            32
`define BSIS_CNT_W            32
`define BSIS_BURST_W          12
`define BSIS_SYNC_IDLE        3'h4
`endif

// ---- design/bsis_uart_rx.v ----
// auxiliary serial byte receiver, 8 data bits, one stop bit, no parity
`include "bsis_consts.vh"
module bsis_uart_rx #(
  parameter integer BIT_CYCLES = 278
) (
  input  wire       clk,
  input  wire       rst,
  input  wire       rxIn,
  output reg  [7:0] dataQ,
  output reg        validQ,
  output reg        frameErrQ
);
  // ----------------------------------------
  // receiver state
  // ----------------------------------------
  localparam [1:0] ST_IDLE  = 2'h0;
  localparam [1:0] ST_START = 2'h1;
  localparam [1:0] ST_DATA  = 2'h2;
  localparam [1:0] ST_STOP  = 2'h3;

  reg [1:0]  stateQ;
  reg [15:0] cntQ;
  reg [2:0]  bitQ;
  reg [7:0]  shQ;

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      stateQ    <= ST_IDLE;
      cntQ      <= 16'h0000;
      bitQ      <= 3'h0;
      shQ       <= 8'h00;
      dataQ     <= 8'h00;
      validQ    <= 1'b0;
      frameErrQ <= 1'b0;
    end else begin
      validQ    <= 1'b0;
      frameErrQ <= 1'b0;
      case (stateQ)
        ST_IDLE: begin
          if (!rxIn) begin
            stateQ <= ST_START;
            cntQ   <= BIT_CYCLES[16:1]; // center of start bit
          end
        end
        ST_START: begin
          if (cntQ == 16'h0000) begin
            if (rxIn) begin
              stateQ <= ST_IDLE; // glitch, not a start bit
            end else begin
              stateQ <= ST_DATA;
              cntQ   <= BIT_CYCLES[15:0] - 16'h0001;
              bitQ   <= 3'h0;
            end
          end else begin
            cntQ <= cntQ - 16'h0001;
          end
        end
        ST_DATA: begin
          if (cntQ == 16'h0000) begin
            shQ  <= {rxIn, shQ[7:1]}; // lsb first
            cntQ <= BIT_CYCLES[15:0] - 16'h0001;
            bitQ <= bitQ + 3'h1;
            if (bitQ == 3'h7) begin
              stateQ <= ST_STOP;
            end
          end else begin
            cntQ <= cntQ - 16'h0001;
          end
        end
        ST_STOP: begin
          if (cntQ == 16'h0000) begin
            stateQ <= ST_IDLE;
            if (rxIn) begin
              dataQ  <= shQ;
              validQ <= 1'b1;
            end else begin
              frameErrQ <= 1'b1;
            end
          end else begin
            cntQ <= cntQ - 16'h0001;
          end
        end
        default: begin
          stateQ <= ST_IDLE;
        end
      endcase
    end
  end
endmodule

// ---- tb/bsis_input_module_properties.sv ----
// checker for sampling, observe-time and monitor behaviour of the input module
module bsis_input_module_properties #(
  parameter integer CLK_HZ     = 200,
  parameter integer MON_CYCLES = 20
) (
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        secondTick,
  input wire logic [2:0]  rateSel,
  input wire logic [2:0]  subsetSel,
  input wire logic [31:0] setSeconds,
  input wire logic [31:0] sampleDataQ,
  input wire logic        sampleValidQ,
  input wire logic        onSecondSampleQ,
  input wire logic        observeTimeMonitorQ,
  input wire logic [31:0] observeSecondsQ,
  input wire logic        observeSetQ,
  input wire logic        auxValidQ
);
  logic [31:0] secCntQ;
  logic [31:0] monCntQ;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      secCntQ <= 32'h0000_0000;
      monCntQ <= 32'h0000_0000;
    end else begin
      secCntQ <= $changed(observeSecondsQ) ? 32'h0000_0000 : secCntQ + 32'h0000_0001;
      monCntQ <= observeTimeMonitorQ ? monCntQ + 32'h0000_0001 : 32'h0000_0000;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // --------------------------------
  // assertions
  // --------------------------------
  sequence tickSeen_s; ##[2:4] onSecondSampleQ; endsequence
  sequence newSecond_s; observeSetQ && $changed(observeSecondsQ); endsequence
  tick_sample_a: assert property ($rose(secondTick) |-> tickSeen_s)
    else $error("tick without on-second sample");
  onsec_valid_a: assert property (onSecondSampleQ |-> sampleValidQ)
    else $error("on-second flag without sample");
  rate_gap_a: assert property (sampleValidQ && rateSel == 3'h1 && $past(rateSel, 2) == 3'h1 && !secondTick
    |=> !sampleValidQ) else $error("sample too early");
  subset_mask_a: assert property (sampleValidQ && subsetSel == 3'h2 && $past(subsetSel, 4) == 3'h2
    |-> sampleDataQ[31:4] == 28'h000_0000) else $error("unselected stream leaked");
  set_load_a: assert property ($rose(observeSetQ) |-> observeSecondsQ == setSeconds)
    else $error("set value not loaded");
  sec_step_a: assert property (observeSetQ && $past(observeSetQ) && $changed(observeSecondsQ)
    |-> observeSecondsQ == $past(observeSecondsQ) + 32'h0000_0001 && secCntQ == CLK_HZ - 1) else $error("bad second step");
  mon_start_a: assert property (newSecond_s |=> observeTimeMonitorQ)
    else $error("monitor did not start");
  mon_idle_a: assert property (!observeSetQ |-> !observeTimeMonitorQ)
    else $error("monitor before set");
  mon_len_a: assert property ($fell(observeTimeMonitorQ) |-> monCntQ == MON_CYCLES)
    else $error("monitor length wrong");
  aux_pulse_a: assert property (auxValidQ |=> !auxValidQ)
    else $error("byte strobe too long");
endmodule
bind bsis_input_module bsis_input_module_properties #(.CLK_HZ(CLK_HZ), .MON_CYCLES(MON_CYCLES)) chk_u (
  .clk(clk), .rst(rst), .secondTick(secondTick), .rateSel(rateSel), .subsetSel(subsetSel),
  .setSeconds(setSeconds), .sampleDataQ(sampleDataQ), .sampleValidQ(sampleValidQ),
  .onSecondSampleQ(onSecondSampleQ), .observeTimeMonitorQ(observeTimeMonitorQ),
  .observeSecondsQ(observeSecondsQ), .observeSetQ(observeSetQ), .auxValidQ(auxValidQ));

// ---- tb/bsis_das_model.sv ----
// acquisition-side model: sampler streams and second tick on the link clock
module bsis_das_model (
  input  wire logic        lclk,
  input  wire logic        tickReq,
  output logic      [31:0] streams,
  output logic             tick
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    streams = 32'h1234_5678;
    tick = 1'b0;
  end
  // samplers run at the full link rate; tick launched with a data edge
  always @(posedge lclk) begin
    streams <= {streams[0], streams[31:1]};
    tick <= tickReq;
  end
endmodule

// ---- tb/bsis_input_module_bench.sv ----
// self-checking bench for the input module
module bsis_input_module_bench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam integer CLKHZ = 200;
  logic clk, rst, lclk, tickReq, altTick, aux, armSet, useAlt, tick, sValid, onSec, mon, setQ, aValid, aOvr;
  logic [2:0]  rateSel, subsetSel;
  logic [31:0] setSec, streams, sData, secQ, nBytes;
  logic [7:0]  aData, lastByte;
  integer errors = 0, testsRun = 0, cycles = 0;
  bsis_das_model das_u (.lclk(lclk), .tickReq(tickReq), .streams(streams), .tick(tick));
  bsis_input_module #(.CLK_HZ(CLKHZ), .MON_CYCLES(20), .BAUD_CYCLES(8)) dut_u (
    .clk(clk), .rst(rst), .inputBitStream(streams), .secondTick(tick), .alternateSecondTick(altTick),
    .auxSerialInput(aux), .rateSel(rateSel), .subsetSel(subsetSel), .useAltTick(useAlt), .armSet(armSet),
    .setSeconds(setSec), .sampleDataQ(sData), .sampleValidQ(sValid), .onSecondSampleQ(onSec),
    .observeTimeMonitorQ(mon), .observeSecondsQ(secQ), .observeSetQ(setQ), .auxDataQ(aData),
    .auxValidQ(aValid), .auxOverrunQ(aOvr));
  initial begin clk = 0; forever #4 clk = ~clk; end
  initial begin lclk = 0; #5; forever #32 lclk = ~lclk; end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 30000) begin errors++; complete_run; end
  end
  always @(posedge clk) if (aValid === 1'b1) begin lastByte <= aData; nBytes <= nBytes + 1; end
  task check(input logic [31:0] act, input logic [31:0] exp);
    testsRun++;
    if (act !== exp) begin errors++; $display("MISMATCH %0t got %h want %h", $time, act, exp); end
  endtask
  task complete_run;
    $display("errors %0d compares %0d", errors, testsRun);
    if (errors == 0 && testsRun > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task rate_subset;
    integer i, j, cnt;
    for (i = 0; i < 5; i++) begin
      @(negedge clk); rateSel = i[2:0]; subsetSel = i[2:0];
      repeat (8) @(negedge clk);
      cnt = 0;
      for (j = 0; j < 32; j++) begin
        @(negedge clk);
        if (sValid === 1'b1) begin cnt++; check(sData & ~((32'h1 << (1 << i)) - 1), 32'h0); end
      end
      check(cnt, 32 >> i);
    end
  endtask
  task set_on_tick;
    integer n;
    logic [31:0] exp;
    @(negedge clk); subsetSel = 3'h2; rateSel = 3'h1; setSec = 32'h0000_0005; armSet = 1; tickReq = 1;
    @(negedge clk); armSet = 0;
    for (n = 0; n < 40 && tick !== 1'b1; n++) @(negedge clk);
    exp = streams & 32'h0000_000f; tickReq = 0;
    for (n = 0; n < 10 && onSec !== 1'b1; n++) @(negedge clk);
    check(sData, exp);
    check(secQ, 32'h0000_0005);
    repeat (CLKHZ + 5) @(negedge clk);
    check(secQ, 32'h0000_0006);
    setSec = 32'h0000_0009; tickReq = 1;
    repeat (12) @(negedge clk); tickReq = 0;
    repeat (20) @(negedge clk);
    check(secQ, 32'h0000_0006);
  endtask
  task send_byte(input logic [7:0] b);
    integer j;
    logic [9:0] frame;
    frame = {1'b1, b, 1'b0};
    for (j = 0; j < 10; j++) begin aux = frame[j]; repeat (8) @(negedge clk); end
  endtask
  task uart_bytes;
    nBytes = 0;
    send_byte(8'hA5);
    send_byte(8'h3C);
    repeat (8) @(negedge clk);
    check(lastByte, 8'h3C);
    check(nBytes, 32'h0000_0002);
    check(aOvr, 1'b0);
  endtask
  task alt_set;
    integer n;
    @(negedge clk); rst = 1;
    @(negedge clk); rst = 0;
    check({31'h0, setQ}, 32'h0);
    check(secQ, 32'h0);
    useAlt = 1; armSet = 1; setSec = 32'h0000_0003;
    @(negedge clk); armSet = 0; altTick = 1;
    repeat (3) @(negedge clk); altTick = 0;
    for (n = 0; n < 10 && setQ !== 1'b1; n++) @(negedge clk);
    check(secQ, 32'h0000_0003);
    repeat (30) @(negedge clk); altTick = 1;
    repeat (3) @(negedge clk); altTick = 0;
    repeat (10) @(negedge clk);
    check(secQ, 32'h0000_0003);
  endtask
  initial begin
    rst = 1; tickReq = 0; altTick = 0; aux = 1; armSet = 0; useAlt = 0;
    rateSel = 3'h0; subsetSel = 3'h0; setSec = 32'h0; nBytes = 0; lastByte = 8'h00;
    repeat (6) @(negedge clk); rst = 0;
    rate_subset;
    set_on_tick;
    uart_bytes;
    alt_set;
    complete_run;
  end
endmodule
